/* include/pll_status_zero_delay_map.vh */
`ifndef PLL_STATUS_ZERO_DELAY_MAP_VH
`define PLL_STATUS_ZERO_DELAY_MAP_VH

// Register addresses on the serial control port.
`define ADDR_WIDTH 13
`define ZERO_DELAY_CONTROL_ADDR 13'h001e
`define PLL_STATUS_READBACK_ADDR 13'h001f

// Zero-delay control fields.
`define ZERO_DELAY_CONTROL_RESET 8'h00
`define ZD_ENABLE_BIT 1
`define ZD_EXTERNAL_BIT 2
`define ZD_DIVIDER_LSB 3
`define ZD_DIVIDER_MSB 4
`define ZD_WRITE_MASK 8'h1e

// Status readback fields.
`define ST_LOCK_BIT 0
`define ST_REF_ONE_ABOVE_BIT 1
`define ST_REF_TWO_ABOVE_BIT 2
`define ST_OSC_ABOVE_BIT 3
`define ST_REF_TWO_SELECTED_BIT 4
`define ST_HOLDOVER_BIT 5
`define ST_CALIBRATION_DONE_BIT 6

// Serial instruction word layout.
`define INSTR_LAST_BIT 4'hf
`define INSTR_READ_BIT 15
`define INSTR_COUNT_MSB 14
`define INSTR_COUNT_LSB 13
`define INSTR_ADDR_MSB 12
`define BYTE_LAST_BIT 4'h7
`define COUNT_STREAM 2'h3

`endif

/* src/serial_edge_sampler.v */
`timescale 1ns/10ps
`default_nettype none

module serial_edge_sampler (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Serial port pins.
  input wire chipSelect_n,
  input wire serialClock,
  input wire serialDataIn,
  // Strobes to the register logic.
  output reg active,
  output reg riseStrobe,
  output reg fallStrobe,
  output reg sampledBit
);

  reg prevSerialClock;

  // The serial clock is treated as a plain synchronous input, so it must run well
  // below half the system clock rate for both edges to be seen.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prevSerialClock <= 1'b0;
      active <= 1'b0;
      riseStrobe <= 1'b0;
      fallStrobe <= 1'b0;
      sampledBit <= 1'b0;
    end else begin
      prevSerialClock <= serialClock;
      active <= !chipSelect_n;
      riseStrobe <= !chipSelect_n && serialClock && !prevSerialClock;
      fallStrobe <= !chipSelect_n && !serialClock && prevSerialClock;
      if (!chipSelect_n && serialClock && !prevSerialClock) begin
        sampledBit <= serialDataIn;
      end
    end
  end

endmodule

`default_nettype wire

/* src/pll_status_zero_delay_regs.v */
// Notes on behaviour
// R01: Enable plus mode bit set selects external.
// R02: Enable with mode bit clear selects internal.
// R03: Enable bit gates zero delay, reset off.
// R04: Status bit 6 shows calibration finished.
// R05: Status bit 5 shows live holdover state.
// R06: Status bit 4 set when reference two feeds.
// R07: Status bit 3 shows oscillator above threshold.
// R08: Status bit 2 shows reference two above threshold.
// R09: Status bit 1 shows reference one above threshold.
// R10: Status bit 0 shows digital lock.
// R11: Status writes ignored; reads return live values.
`timescale 1ns/10ps
`default_nettype none
`include "pll_status_zero_delay_map.vh"

module pll_status_zero_delay_regs (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Serial control port.
  input wire chipSelect_n,
  input wire serialClock,
  input wire serialDataIn,
  output reg serialDataOut,
  output reg serialDataOutEnable,
  // Live status sources.
  input wire calibrationDone,
  input wire holdoverActive,
  input wire referenceInputTwoSelected,
  input wire oscillatorAboveThreshold,
  input wire referenceInputTwoAboveThreshold,
  input wire referenceInputOneAboveThreshold,
  input wire digitalLock,
  // Zero-delay controls to the clock path.
  output reg zeroDelayEnable,
  output reg externalZeroDelay,
  output reg internalZeroDelay,
  output reg [1:0] feedbackDividerSelect
);

  localparam [1:0] STATE_IDLE = 2'b00;
  localparam [1:0] STATE_INSTR = 2'b01;
  localparam [1:0] STATE_DATA = 2'b10;
  localparam [1:0] STATE_DONE = 2'b11;

  ////////////////////////////////////////////////////////////////////////////////

  wire active;
  wire riseStrobe;
  wire fallStrobe;
  wire sampledBit;

  serial_edge_sampler edgeSampler (
    .clock(clock),
    .rst(rst),
    .chipSelect_n(chipSelect_n),
    .serialClock(serialClock),
    .serialDataIn(serialDataIn),
    .active(active),
    .riseStrobe(riseStrobe),
    .fallStrobe(fallStrobe),
    .sampledBit(sampledBit)
  );

  ////////////////////////////////////////////////////////////////////////////////

  reg [1:0] state;
  reg [3:0] bitCount;
  reg [15:0] instrShift;
  reg [7:0] dataShift;
  reg [7:0] readShift;
  reg [`ADDR_WIDTH-1:0] address;
  reg [1:0] bytesLeft;
  reg streaming;
  reg isRead;
  reg [7:0] zeroDelayControl;

  wire [15:0] fullInstr;
  wire [7:0] fullData;
  wire [7:0] liveStatus;
  wire lastByte;

  assign fullInstr = {instrShift[14:0], sampledBit};
  assign fullData = {dataShift[6:0], sampledBit};
  assign lastByte = !streaming && (bytesLeft == 2'h0);

  // Status is assembled from the live sources, never from a stored copy.
  assign liveStatus = {1'b0,
                       calibrationDone, // see R04
                       holdoverActive, // see R05
                       referenceInputTwoSelected, // see R06
                       oscillatorAboveThreshold, // see R07
                       referenceInputTwoAboveThreshold, // see R08
                       referenceInputOneAboveThreshold, // see R09
                       digitalLock}; // see R10

  // Unmapped addresses read as zero.
  function [7:0] readValue;
    input [`ADDR_WIDTH-1:0] addr;
    input [7:0] control;
    input [7:0] status;
    begin
      if (addr == `ZERO_DELAY_CONTROL_ADDR) begin
        readValue = control;
      end else if (addr == `PLL_STATUS_READBACK_ADDR) begin
        readValue = status;
      end else begin
        readValue = 8'h00;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame: 16-bit instruction, then data bytes at descending addresses.

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= STATE_IDLE;
      bitCount <= 4'h0;
      instrShift <= 16'h0000;
      dataShift <= 8'h00;
      readShift <= 8'h00;
      address <= 13'h0000;
      bytesLeft <= 2'h0;
      streaming <= 1'b0;
      isRead <= 1'b0;
      zeroDelayControl <= `ZERO_DELAY_CONTROL_RESET; // see R03
      serialDataOut <= 1'b0;
      serialDataOutEnable <= 1'b0;
    end else if (!active) begin
      // Raising chip select aborts any frame; a partial byte is dropped.
      state <= STATE_IDLE;
      bitCount <= 4'h0;
      isRead <= 1'b0;
      serialDataOutEnable <= 1'b0;
    end else begin
      serialDataOutEnable <= isRead && (state == STATE_DATA);
      if (riseStrobe) begin
        case (state)
          STATE_IDLE: begin
            instrShift <= {15'h0000, sampledBit};
            bitCount <= 4'h1;
            state <= STATE_INSTR;
          end
          STATE_INSTR: begin
            instrShift <= fullInstr;
            if (bitCount == `INSTR_LAST_BIT) begin
              isRead <= fullInstr[`INSTR_READ_BIT];
              bytesLeft <= fullInstr[`INSTR_COUNT_MSB:`INSTR_COUNT_LSB];
              streaming <= fullInstr[`INSTR_COUNT_MSB:`INSTR_COUNT_LSB] == `COUNT_STREAM;
              address <= fullInstr[`INSTR_ADDR_MSB:0];
              // The read value is captured as the instruction completes.
              readShift <= readValue(fullInstr[`INSTR_ADDR_MSB:0],
                                     zeroDelayControl, liveStatus); // see R11
              bitCount <= 4'h0;
              state <= STATE_DATA;
            end else begin
              bitCount <= bitCount + 4'h1;
            end
          end
          STATE_DATA: begin
            dataShift <= fullData;
            if (bitCount == `BYTE_LAST_BIT) begin
              bitCount <= 4'h0;
              address <= address - 13'h0001;
              // Only the control register takes writes; status writes are dropped.
              if (!isRead && address == `ZERO_DELAY_CONTROL_ADDR) begin
                zeroDelayControl <= fullData & `ZD_WRITE_MASK; // see R11
              end
              if (isRead) begin
                readShift <= readValue(address - 13'h0001, zeroDelayControl, liveStatus);
              end
              if (lastByte) begin
                state <= STATE_DONE;
              end else if (!streaming) begin
                bytesLeft <= bytesLeft - 2'h1;
              end
            end else begin
              bitCount <= bitCount + 4'h1;
            end
          end
          STATE_DONE: begin
            bitCount <= 4'h0;
          end
          default: begin
            state <= STATE_IDLE;
          end
        endcase
      end else if (fallStrobe && isRead && state == STATE_DATA) begin
        serialDataOut <= readShift[7];
        readShift <= {readShift[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Zero-delay mode decode, registered so each output comes from a flip-flop.

  reg next_zeroDelayEnable;
  reg next_externalZeroDelay;
  reg next_internalZeroDelay;

  always @* begin
    next_zeroDelayEnable = zeroDelayControl[`ZD_ENABLE_BIT]; // see R03
    next_externalZeroDelay = zeroDelayControl[`ZD_ENABLE_BIT] &&
                             zeroDelayControl[`ZD_EXTERNAL_BIT]; // see R01
    next_internalZeroDelay = zeroDelayControl[`ZD_ENABLE_BIT] &&
                             !zeroDelayControl[`ZD_EXTERNAL_BIT]; // see R02
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      zeroDelayEnable <= 1'b0;
      externalZeroDelay <= 1'b0;
      internalZeroDelay <= 1'b0;
      feedbackDividerSelect <= 2'h0;
    end else begin
      zeroDelayEnable <= next_zeroDelayEnable;
      externalZeroDelay <= next_externalZeroDelay;
      internalZeroDelay <= next_internalZeroDelay;
      feedbackDividerSelect <= zeroDelayControl[`ZD_DIVIDER_MSB:`ZD_DIVIDER_LSB];
    end
  end

endmodule

`default_nettype wire

/* verification/pll_status_zero_delay_regs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module pll_status_zero_delay_regs_checker (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Observed pins.
  input wire chipSelect_n,
  input wire serialClock,
  input wire serialDataOut,
  input wire serialDataOutEnable,
  input wire zeroDelayEnable,
  input wire externalZeroDelay,
  input wire internalZeroDelay
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |-> !zeroDelayEnable && !serialDataOutEnable) else $error("output active in reset");
  external_mode_a: assert property (externalZeroDelay |-> zeroDelayEnable && !internalZeroDelay)
    else $error("external mode without enable");
  internal_mode_a: assert property (internalZeroDelay |-> zeroDelayEnable)
    else $error("internal mode without enable");
  mode_chosen_a: assert property (zeroDelayEnable |-> externalZeroDelay || internalZeroDelay)
    else $error("enable without mode");
  // Control outputs may only move as a result of a serial write.
  zd_quiet_a: assert property (chipSelect_n [*4] |-> $stable(zeroDelayEnable))
    else $error("enable moved outside a frame");
  zd_in_frame_a: assert property ($rose(externalZeroDelay) |-> !$past(chipSelect_n, 3))
    else $error("external mode rose outside a frame");
  read_release_a: assert property (chipSelect_n [*4] |-> !serialDataOutEnable)
    else $error("read data still driven");
  read_start_a: assert property ($rose(serialDataOutEnable) |-> !$past(chipSelect_n))
    else $error("drive began without select");
  data_after_fall_a: assert property (
    serialDataOutEnable && $changed(serialDataOut) |-> !$past(serialClock))
    else $error("read data changed while clock high");
endmodule
bind pll_status_zero_delay_regs pll_status_zero_delay_regs_checker u_chk (.clock, .rst,
  .chipSelect_n, .serialClock, .serialDataOut, .serialDataOutEnable, .zeroDelayEnable,
  .externalZeroDelay, .internalZeroDelay);
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pll_status_zero_delay_map.vh"
module testbench;
  logic clock = 1'b0, rst = 1'b0, chipSelect_n = 1'b1, serialClock = 1'b0, serialDataIn = 1'b0;
  logic [6:0] stat = 7'h00;
  logic [15:0] rd;
  wire serialDataOut, serialDataOutEnable, zeroDelayEnable, externalZeroDelay, internalZeroDelay;
  wire [1:0] feedbackDividerSelect;
  // A released data line floats high, as a pull-up would hold it, so a missing enable shows.
  wire serialLine = serialDataOutEnable ? serialDataOut : 1'b1;
  int errCount = 0;
  int totalChecks = 0;
  pll_status_zero_delay_regs u_pll_status_zero_delay_regs (.clock, .rst, .chipSelect_n,
    .serialClock, .serialDataIn, .serialDataOut, .serialDataOutEnable,
    .calibrationDone(stat[6]), .holdoverActive(stat[5]), .referenceInputTwoSelected(stat[4]),
    .oscillatorAboveThreshold(stat[3]), .referenceInputTwoAboveThreshold(stat[2]),
    .referenceInputOneAboveThreshold(stat[1]), .digitalLock(stat[0]), .zeroDelayEnable,
    .externalZeroDelay, .internalZeroDelay, .feedbackDividerSelect);
  initial begin
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic closeOut;
    if (errCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Each serial half period lasts four clocks, one more than the three a read needs, to leave sampling margin.
  task automatic xfer(input logic [15:0] ins, input logic [15:0] wd, input int n);
    logic [31:0] sh;
    sh = {ins, wd};
    @(posedge clock) chipSelect_n <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 16 + 8 * n; i++) begin
      serialDataIn <= sh[31 - i];
      repeat (4) @(posedge clock);
      rd = {rd[14:0], serialLine};
      serialClock <= 1'b1;
      repeat (4) @(posedge clock);
      serialClock <= 1'b0;
    end
    repeat (4) @(posedge clock);
    chipSelect_n <= 1'b1;
    serialDataIn <= ~serialDataIn;
    repeat (4) @(posedge clock);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    xfer({3'b000, a}, {v, 8'h00}, 1);
  endtask
  task automatic rdb(input logic [12:0] a, input int n);
    xfer({1'b1, 2'(n - 1), a}, 16'h0000, n);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic ctrlModes;
    logic [7:0] v [6] = '{8'h02, 8'h06, 8'h04, 8'h1e, 8'hff, 8'h00};
    chk({zeroDelayEnable, externalZeroDelay, internalZeroDelay, feedbackDividerSelect}, 5'h00);
    rdb(`ZERO_DELAY_CONTROL_ADDR, 1);
    chk(rd[7:0], 8'h00);
    foreach (v[i]) begin
      wr(`ZERO_DELAY_CONTROL_ADDR, v[i]);
      rdb(`ZERO_DELAY_CONTROL_ADDR, 1);
      chk(rd[7:0], v[i] & 8'h1e);
      chk({zeroDelayEnable, externalZeroDelay, internalZeroDelay},
        {v[i][1], v[i][1] & v[i][2], v[i][1] & ~v[i][2]});
      chk(feedbackDividerSelect, v[i][4:3]);
    end
  endtask
  task automatic statusWalk;
    logic [6:0] p;
    for (int i = 0; i < 14; i++) begin
      p = 7'h01 << (i % 7);
      if (i > 6) p = ~p;
      @(posedge clock) stat <= p;
      rdb(`PLL_STATUS_READBACK_ADDR, 1);
      chk(rd[7:0], {1'b0, p});
    end
  endtask
  task automatic readOnly;
    wr(`ZERO_DELAY_CONTROL_ADDR, 8'h0a);
    wr(`PLL_STATUS_READBACK_ADDR, 8'hff);
    @(posedge clock) stat <= 7'h2a;
    rdb(`PLL_STATUS_READBACK_ADDR, 2);
    chk(rd, 16'h2a0a);
    chk({zeroDelayEnable, internalZeroDelay, feedbackDividerSelect}, 4'hd);
    wr(13'h0020, 8'hff);
    rdb(13'h0020, 1);
    chk(rd[7:0], 8'h00);
  endtask
  initial begin
    // A real edge on reset clears the design before the first clock edge is sampled.
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    ctrlModes;
    statusWalk;
    readOnly;
    closeOut;
  end
  initial begin
    repeat (30000) @(posedge clock);
    errCount++;
    closeOut;
  end
endmodule
`default_nettype wire
